// File: core/pd_power_map.svh
// Purpose: offsets, field positions and timing counts for the pd power fsm
// Assumes: 50 MHz clock
// Notes: register map over ahb-lite, word aligned byte addresses
`ifndef PD_POWER_MAP_SVH
`define PD_POWER_MAP_SVH
`define CLOCK_HZ 50000000
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define CLASS_OFFSET 8'h08
`define TX_OFFSET 8'h0C
`define CTRL_RESET 32'h00000000
`define CTRL_SOFT_HOLD_BIT 0
`define POWER_DELAY_TIME_MS 81
`define POWER_DELAY_CYCLES ((`POWER_DELAY_TIME_MS * (`CLOCK_HZ / 1000)))
`define RESET_PULSE_TIME_MS 5
`define RESET_PULSE_CYCLES ((`RESET_PULSE_TIME_MS * (`CLOCK_HZ / 1000)))
`define WATCHDOG_TIME_MS 1320
`define WATCHDOG_CYCLES ((`WATCHDOG_TIME_MS * (`CLOCK_HZ / 1000)))
`endif

// File: core/pd_power_pkg.sv
// Purpose: types for the pd power fsm
// Assumes: nothing
// Notes: states encoded in binary
package pd_power_pkg;
	typedef enum logic [2:0] {
		st_reset = 3'h0,
		st_wakeup = 3'h1,
		st_classify = 3'h2,
		st_first_powered = 3'h3,
		st_power_delay = 3'h4,
		st_fully_powered = 3'h5,
		st_disconnect = 3'h6
	} port_state_type;
	typedef enum logic [1:0] {
		tri_low = 2'h0,
		tri_float = 2'h1,
		tri_high = 2'h2
	} ternary_type;
endpackage

// File: core/level_qualify.sv
// Purpose: three-flop qualifier for one asynchronous level
// Assumes: input from outside the clock domain
// Notes: output changes once second and third stages agree
`timescale 1ns/1ps
module level_qualify (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// level
	input wire logic raw,
	output logic level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	// first stage feeds only the second
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// agreement of stages two and three qualifies a change
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			level <= 1'b0;
		else if (s2_reg == s3_reg)
			level <= s3_reg;
	end
endmodule // level_qualify

// File: core/pd_power_fsm.sv
// Purpose: powered-device port state machine for single-pair power
// Assumes: analog front end gives comparator levels; one 50 MHz clock
// Notes: registers reached over ahb-lite; outputs registered
// Behaviour
// - class_voltage_select low picks classes 10-12, high picks 13-15
// - ternary class_current_select with voltage select picks class 10-15
// - enable high only when powered and high-side switch is enhanced
// - logic 0 during classification drives pull-down to both switches
// - start in reset, turn on exactly one polarity gate from sense inputs
// - leave reset for wakeup only once that polarity gate is enhanced
// - wakeup state presents the wakeup current signature
// - above on threshold and after power delay, enter fully powered
// - ramp high-side gate on full power, enable after ramp completes
// - below off threshold, enter disconnect and drop enable
// - from disconnect, sleep-range voltage returns to wakeup
// - classification reports configured voltage and current class
// - no cable resistance measurement is offered
// - act on unrectified port voltage, polarity sensed automatically
// - valid reset pulse in wakeup advances to classification
// - classification watchdog expiry falls back to wakeup
// - power delay timer over 80 ms, then fully powered
// - first powered state disables signature and pull-down drive
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pd_power_map.svh"
module pd_power_fsm #(
	parameter int DELAY_CYCLES = `POWER_DELAY_CYCLES,
	parameter int PULSE_CYCLES = `RESET_PULSE_CYCLES,
	parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// analog front end levels
	input wire logic line_sense_a,
	input wire logic line_sense_b,
	input wire logic polarity_enhanced,
	input wire logic above_on,
	input wire logic below_off,
	input wire logic in_sleep,
	input wire logic gate_enhanced,
	input wire logic line_low,
	// class straps
	input wire logic class_voltage_select,
	input wire logic [1:0] class_current_select,
	// drives
	output logic polarity_gate_a,
	output logic polarity_gate_b,
	output logic wakeup_signature,
	output logic pulldown_drive,
	output logic gate_ramp,
	output logic enable_out,
	output pd_power_pkg::port_state_type state_out
);
	import pd_power_pkg::*;

	// refuse counts that the shared timer cannot serve
	if (DELAY_CYCLES < 1 || PULSE_CYCLES < 1 ||
		WATCHDOG_CYCLES < 1) begin : g_bad_counts
		$error("pd_power_fsm: counts must be at least one");
	end

	// reset release through two flops
	logic rst_a_reg;
	logic reset_n;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_a_reg <= 1'b0;
			reset_n <= 1'b0;
		end else begin
			rst_a_reg <= 1'b1;
			reset_n <= rst_a_reg;
		end
	end

	// qualify every asynchronous level
	localparam int NQ = 11;
	logic [NQ-1:0] raw_in;
	logic [NQ-1:0] q_in;
	assign raw_in = {class_current_select, class_voltage_select, line_low,
		gate_enhanced, in_sleep, below_off, above_on, polarity_enhanced,
		line_sense_b, line_sense_a};
	genvar gi;
	generate
		for (gi = 0; gi < NQ; gi++) begin : g_q
			level_qualify u_q (
				.clock(clock),
				.reset_n(reset_n),
				.raw(raw_in[gi]),
				.level(q_in[gi])
			);
		end
	endgenerate
	logic sense_a_q, sense_b_q, pol_ok_q, on_q, off_q, sleep_q;
	logic gate_ok_q, low_q, cv_q;
	logic [1:0] cc_q;
	assign {cc_q, cv_q, low_q, gate_ok_q, sleep_q, off_q, on_q, pol_ok_q,
		sense_b_q, sense_a_q} = q_in;

	// ternary decode of the current strap
	function automatic ternary_type decode_tri(input logic [1:0] v);
		if (v == 2'h3)
			return tri_high;
		else if (v == 2'h0)
			return tri_low;
		else
			return tri_float;
	endfunction

	// class 10..15 from both straps
	logic [3:0] class_reg;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			class_reg <= 4'hA;
		else
			class_reg <= (cv_q ? 4'hD : 4'hA) + {2'h0, decode_tri(cc_q)};
	end

	// software control: hold-off bit and class-report transmit bit
	logic [31:0] ctrl_reg;
	logic tx_zero_reg;

	port_state_type state_reg, state_next;
	logic [31:0] timer_reg;
	logic pol_sel_reg; // 0 selects gate a
	logic pulse_done;
	logic delay_done;
	logic wd_done;
	assign pulse_done = (timer_reg >= 32'(PULSE_CYCLES - 1));
	assign delay_done = (timer_reg >= 32'(DELAY_CYCLES - 1));
	assign wd_done = (timer_reg >= 32'(WATCHDOG_CYCLES - 1));

	// next state, decided from unrectified qualified levels
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			st_reset:
				if (pol_ok_q && !ctrl_reg[`CTRL_SOFT_HOLD_BIT])
					state_next = st_wakeup;
			st_wakeup:
				if (low_q && pulse_done)
					state_next = st_classify;
			st_classify:
				if (on_q)
					state_next = st_first_powered;
				else if (wd_done)
					state_next = st_wakeup;
			st_first_powered:
				if (on_q)
					state_next = st_power_delay;
				else if (sleep_q)
					state_next = st_wakeup;
			st_power_delay:
				if (off_q)
					state_next = st_disconnect;
				else if (delay_done)
					state_next = st_fully_powered;
			st_fully_powered:
				if (off_q)
					state_next = st_disconnect;
			st_disconnect:
				if (sleep_q)
					state_next = st_wakeup;
			default:
				state_next = st_reset;
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			state_reg <= st_reset;
		else
			state_reg <= state_next;
	end

	// one timer: pulse width, watchdog or power delay
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			timer_reg <= 32'h00000000;
		else if (state_next != state_reg)
			timer_reg <= 32'h00000000;
		else if (state_reg == st_wakeup && !low_q)
			timer_reg <= 32'h00000000; // pulse must be continuous
		else if (timer_reg != 32'hFFFFFFFF)
			timer_reg <= timer_reg + 32'h00000001;
	end

	// polarity choice latched while in reset; line a high picks gate a
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			pol_sel_reg <= 1'b0;
		else if (state_reg == st_reset)
			pol_sel_reg <= !(sense_a_q || !sense_b_q);
	end

	// drive outputs straight from flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			polarity_gate_a <= 1'b0;
			polarity_gate_b <= 1'b0;
			wakeup_signature <= 1'b0;
			pulldown_drive <= 1'b0;
			gate_ramp <= 1'b0;
			enable_out <= 1'b0;
			state_out <= st_reset;
		end else begin
			polarity_gate_a <= !pol_sel_reg;
			polarity_gate_b <= pol_sel_reg;
			wakeup_signature <= (state_next == st_wakeup);
			// both switches regardless of polarity
			pulldown_drive <= (state_next == st_classify) && tx_zero_reg;
			gate_ramp <= (state_next == st_fully_powered);
			enable_out <= (state_next == st_fully_powered) &&
				gate_ok_q && gate_ramp;
			state_out <= state_next;
		end
	end

	// ahb-lite address phase capture
	logic ap_valid_reg;
	logic ap_write_reg;
	logic [7:0] ap_addr_reg;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_addr_reg <= 8'h00;
		end else if (hready) begin
			ap_valid_reg <= hsel && htrans[1];
			ap_write_reg <= hwrite;
			ap_addr_reg <= haddr;
		end
	end

	// register writes; bit 0 of tx holds the class-report bit to send
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= `CTRL_RESET;
			tx_zero_reg <= 1'b0;
		end else begin
			if (ap_valid_reg && ap_write_reg) begin
				if (ap_addr_reg == `CTRL_OFFSET)
					ctrl_reg <= hwdata;
				if (ap_addr_reg == `TX_OFFSET)
					tx_zero_reg <= !hwdata[0];
			end
			if (state_reg != st_classify)
				tx_zero_reg <= 1'b0;
		end
	end

	// read data, zero-wait; class register reports straps
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hrdata <= 32'h00000000;
		end else if (hsel && htrans[1] && hready && !hwrite) begin
			unique case (haddr)
				`CTRL_OFFSET: hrdata <= ctrl_reg;
				`STATUS_OFFSET: hrdata <= {26'h0, enable_out, gate_ramp,
					1'b0, state_reg};
				`CLASS_OFFSET: hrdata <= {28'h0, class_reg};
				`TX_OFFSET: hrdata <= {31'h0, !tx_zero_reg};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// always ready, always okay
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	sequence s_full_entry;
		state_reg != st_fully_powered ##1 state_reg == st_fully_powered;
	endsequence

	// output flops load one edge after release, so gate exclusivity
	// is only judged once they have left their reset values
	chk_enable_when_powered: assert property (@(posedge clock)
		disable iff (!reset_n) enable_out |-> state_reg == st_fully_powered)
		else $error("enable outside full power");
	chk_enable_switch: assert property (@(posedge clock)
		disable iff (!reset_n) enable_out |-> $past(gate_ok_q))
		else $error("enable without enhanced switch");
	chk_enable_after_ramp: assert property (@(posedge clock)
		disable iff (!reset_n) s_full_entry |-> !enable_out)
		else $error("enable before ramp");
	chk_one_gate: assert property (@(posedge clock)
		disable iff (!reset_n) $past(reset_n) |->
		polarity_gate_a != polarity_gate_b)
		else $error("polarity gates not exclusive");
	chk_reset_exit: assert property (@(posedge clock)
		disable iff (!reset_n) state_reg == st_reset ##1
		state_reg == st_wakeup |-> $past(pol_ok_q))
		else $error("left reset unenhanced");
	chk_sig_wakeup: assert property (@(posedge clock)
		disable iff (!reset_n) wakeup_signature == (state_reg == st_wakeup))
		else $error("signature mismatch");
	chk_pulldown_class: assert property (@(posedge clock)
		disable iff (!reset_n) pulldown_drive |-> state_reg == st_classify)
		else $error("pull-down outside classification");
	chk_wakeup_pulse: assert property (@(posedge clock)
		disable iff (!reset_n) state_reg == st_wakeup ##1
		state_reg == st_classify |-> $past(low_q) && $past(pulse_done))
		else $error("classification without reset pulse");
	chk_watchdog_exit: assert property (@(posedge clock)
		disable iff (!reset_n) state_reg == st_classify ##1
		state_reg == st_wakeup |-> $past(wd_done))
		else $error("left classification before watchdog");
	chk_pd_quiet: assert property (@(posedge clock)
		disable iff (!reset_n) state_reg == st_first_powered |->
		!wakeup_signature && !pulldown_drive)
		else $error("first powered not quiet");
	chk_off_disc: assert property (@(posedge clock)
		disable iff (!reset_n) state_reg == st_fully_powered && off_q |=>
		state_reg == st_disconnect ##1 !enable_out)
		else $error("no disconnect on off level");
	chk_sleep_return: assert property (@(posedge clock)
		disable iff (!reset_n) state_reg == st_disconnect ##1
		state_reg == st_wakeup |-> $past(sleep_q))
		else $error("wakeup before sleep range");
	chk_delay_len: assert property (@(posedge clock)
		disable iff (!reset_n) state_reg == st_power_delay ##1
		state_reg == st_fully_powered |-> $past(delay_done))
		else $error("power delay too short");
	chk_class_range: assert property (@(posedge clock)
		disable iff (!reset_n) class_reg >= 4'hA && class_reg <= 4'hF)
		else $error("class out of range");
endmodule // pd_power_fsm

// File: tb/pse_model.sv
// Purpose: sourcing equipment seen as port-voltage comparator levels
// Assumes: cmd 0 sleep, 1 reset pulse, 2 full voltage, 3 removed
// Notes: levels change right after an edge like a real supply ramp
`timescale 1ns/1ps
module pse_model #(
	parameter int PULSE = 10
) (
	// clock
	input wire logic clock,
	// command from the bench
	input wire logic [1:0] cmd,
	// port voltage levels
	output logic above_on,
	output logic below_off,
	output logic in_sleep,
	output logic line_low
);
	int cnt = 0;
	// full voltage only while the bench commands it
	always_ff @(posedge clock) begin
		cnt <= (cmd == 2'h1) ? cnt + 1 : 0;
		above_on <= (cmd == 2'h2);
		below_off <= (cmd != 2'h2);
		in_sleep <= (cmd == 2'h0) || (cmd == 2'h1);
		// pulse held a little past the minimum, then released high
		line_low <= (cmd == 2'h1) && (cnt < PULSE + 6);
	end
endmodule // pse_model

// File: tb/single_pair_pd_power_fsm_tb.sv
// Purpose: self-checking bench for the port state machine
// Assumes: shortened delay, pulse and watchdog counts
// Notes: bus tasks hold each phase until hreadyout is sampled high
`timescale 1ns/1ps
module single_pair_pd_power_fsm_tb;
	import pd_power_pkg::*;
	logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0, cmd = 2'h0, ccur = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	logic hreadyout, hresp, sa = 1, pe = 0, ge = 0, cv = 0;
	logic above_on, below_off, in_sleep, line_low;
	logic ga, gb, sig, pd, ramp, en;
	port_state_type st;
	int fails = 0, num_checks = 0, cyc = 0, n;
	always #10 clock = ~clock;
	pse_model #(.PULSE(10)) pse (.clock(clock), .cmd(cmd),
		.above_on(above_on), .below_off(below_off), .in_sleep(in_sleep),
		.line_low(line_low));
	pd_power_fsm #(.DELAY_CYCLES(50), .PULSE_CYCLES(10),
		.WATCHDOG_CYCLES(100)) uut (.clock(clock), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .line_sense_a(sa),
		.line_sense_b(~sa), .polarity_enhanced(pe), .above_on(above_on),
		.below_off(below_off), .in_sleep(in_sleep), .gate_enhanced(ge),
		.line_low(line_low), .class_voltage_select(cv),
		.class_current_select(ccur), .polarity_gate_a(ga),
		.polarity_gate_b(gb), .wakeup_signature(sig), .pulldown_drive(pd),
		.gate_ramp(ramp), .enable_out(en), .state_out(st));
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bus cycle; read data taken at the data-phase edge
	task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rd = hrdata;
	endtask
	task automatic wait_state(port_state_type s, int lim);
		n = 0;
		while (st !== s && n < lim) begin
			@(posedge clock);
			n++;
		end
		check("state", st, s);
	endtask
	// power-up: one polarity gate, then wakeup once it is enhanced
	task automatic t_powerup();
		repeat (10) @(posedge clock);
		check("gate_a", ga, 1);
		check("gate_b", gb, 0);
		check("held", st, st_reset);
		pe <= 1;
		wait_state(st_wakeup, 40);
		check("signature", sig, 1);
	endtask
	// every strap pairing read back as a class number
	task automatic t_class();
		for (int i = 0; i < 6; i++) begin
			cv <= (i > 2);
			ccur <= (i % 3 == 0) ? 2'h0 : (i % 3 == 1) ? 2'h1 : 2'h3;
			repeat (12) @(posedge clock);
			bus(0, 8'h08, 32'h0);
			check("class", rd, 10 + i);
		end
		bus(0, 8'h10, 32'h0);
		check("unmapped", rd, 32'h0);
		check("hresp", hresp, 32'h0);
	endtask
	// classify, pull-down on a zero bit, then the full power path
	task automatic t_power();
		cmd <= 2'h1;
		wait_state(st_classify, 60);
		bus(1, 8'h0C, 32'h0);
		repeat (3) @(posedge clock);
		check("pulldown", pd, 1);
		cmd <= 2'h2;
		wait_state(st_first_powered, 40);
		check("sig_off", sig, 0);
		check("pd_off", pd, 0);
		wait_state(st_power_delay, 40);
		n = 0;
		while (st === st_power_delay && n < 200) begin
			@(posedge clock);
			n++;
		end
		check("delay_ok", n >= 50, 1);
		check("full", st, st_fully_powered);
		repeat (5) @(posedge clock);
		check("ramp", ramp, 1);
		check("en_early", en, 0);
		ge <= 1;
		repeat (10) @(posedge clock);
		check("enable", en, 1);
		bus(0, 8'h04, 32'h0);
		check("status", rd, {26'h0, 3'h6, 3'h5});
		cmd <= 2'h3;
		wait_state(st_disconnect, 40);
		check("en_drop", en, 0);
		ge <= 0;
		cmd <= 2'h0;
		wait_state(st_wakeup, 40);
	endtask
	// reset pulse but no power: watchdog returns to wakeup
	task automatic t_watchdog();
		cmd <= 2'h1;
		wait_state(st_classify, 60);
		repeat (60) @(posedge clock);
		check("wd_hold", st, st_classify);
		wait_state(st_wakeup, 120);
		cmd <= 2'h0;
	endtask
	// second power-up with reversed polarity picks the other gate
	task automatic t_reverse();
		rst_n <= 0;
		sa <= 0;
		pe <= 0;
		repeat (16) @(posedge clock);
		rst_n <= 1;
		repeat (10) @(posedge clock);
		check("rev_gate_a", ga, 0);
		check("rev_gate_b", gb, 1);
		check("rev_held", st, st_reset);
		pe <= 1;
		wait_state(st_wakeup, 40);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1;
		t_powerup();
		t_class();
		t_power();
		t_watchdog();
		t_reverse();
		finish_test();
	end
endmodule // single_pair_pd_power_fsm_tb
